//--- core/dlp_regs.sv
// Parameter register bank of the drawing engine
`timescale 1ns/1ps
`default_nettype none
module dlp_regs
  import dlp_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [7:0] sys_config_i,
  input wire dlp_bus_t bus_i,
  output logic [15:0] rdata_o,
  output logic rvalid_o,
  input wire logic cmd_start_i,
  input wire logic cmd_done_i,
  input wire logic pos_upd_i,
  input wire logic [11:0] pos_x_i,
  input wire logic [11:0] pos_x2_i,
  output dlp_params_t params_o,
  output logic busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Offset table, one entry per register
  localparam logic [15:0] OFFS [DLP_NREG] = '{DLP_OFF_START_X, DLP_OFF_START_X2, DLP_OFF_DEST_Y,
    DLP_OFF_Y2, DLP_OFF_DEST_X, DLP_OFF_X2, DLP_OFF_ERR, DLP_OFF_ERR2, DLP_OFF_PCNT};
  // Start X, second start X and pixel count keep 12 bits; Y, X and error registers keep 14
  localparam logic [15:0] MASKS [DLP_NREG] = '{DLP_COORD_MASK, DLP_COORD_MASK, DLP_STEP_MASK,
    DLP_STEP_MASK, DLP_STEP_MASK, DLP_STEP_MASK, DLP_STEP_MASK, DLP_STEP_MASK, DLP_COORD_MASK};

  logic [15:0] regs [DLP_NREG];
  logic [15:0] next_regs [DLP_NREG];
  logic [DLP_NREG-1:0] hit;
  logic access_en;
  dlp_state_t state, next_state;
  dlp_params_t params, next_params;
  logic [15:0] rdata, next_rdata;
  logic rvalid, next_rvalid;
  logic busy, next_busy;

  assign access_en = sys_config_i[DLP_ENABLE_BIT]; // R19

  genvar g;
  generate
    for (g = 0; g < DLP_NREG; g++) begin : g_dec
      assign hit[g] = (bus_i.addr == OFFS[g]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register storage and live position tracking
  always_comb begin
    for (int i = 0; i < DLP_NREG; i++) begin
      next_regs[i] = regs[i];
      if (access_en && bus_i.wr && hit[i]) begin
        next_regs[i] = bus_i.wdata & MASKS[i]; // R17 R18 R07 R10 R12 R14 R16
      end
    end
    // Engine position overrides host value so reads follow drawing
    if (state == DLP_RUN && pos_upd_i) begin
      next_regs[0] = {4'h0, pos_x_i}; // R04
      next_regs[1] = {4'h0, pos_x2_i}; // R05
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < DLP_NREG; i++) begin
        regs[i] <= DLP_RESET_VAL;
      end
    end else if (ce_i) begin
      for (int i = 0; i < DLP_NREG; i++) begin
        regs[i] <= next_regs[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command snapshot; engine uses the copy, so later writes wait
  always_comb begin
    next_state = state;
    next_params = params;
    unique case (state)
      DLP_IDLE: begin
        if (cmd_start_i) begin
          next_state = DLP_RUN;
          next_params.start_x = regs[0]; // R01 R02 R03
          next_params.start_x2 = regs[1]; // R05
          next_params.dest_y = regs[2]; // R06 R07
          next_params.y2 = regs[3]; // R08
          next_params.dest_x = regs[4]; // R09 R10
          next_params.x2 = regs[5]; // R11
          next_params.err = regs[6]; // R12
          next_params.err2 = regs[7]; // R14
          next_params.pcnt = regs[8]; // R15 R16
        end
      end
      DLP_RUN: begin
        if (cmd_done_i) begin
          next_state = DLP_IDLE; // R20
        end
      end
    endcase
    next_busy = (next_state == DLP_RUN);
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      state <= DLP_IDLE;
      params <= '0;
      busy <= 1'b0;
    end else if (ce_i) begin
      state <= next_state;
      params <= next_params;
      busy <= next_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port, one cycle latency; unmapped or disabled reads give zero
  always_comb begin
    next_rdata = '0;
    next_rvalid = bus_i.rd;
    for (int i = 0; i < DLP_NREG; i++) begin
      if (access_en && bus_i.rd && hit[i]) begin
        next_rdata = regs[i]; // R04 R18
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      rdata <= '0;
      rvalid <= 1'b0;
    end else if (ce_i) begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  assign rdata_o = rdata;
  assign rvalid_o = rvalid;
  assign params_o = params;
  assign busy_o = busy;

endmodule
`default_nettype wire

//--- include/dlp_pkg.sv
// Package for the line drawing parameter register set
// Function
// [R01] Start X is first pixel X
// [R02] Start X begins first polygon edge
// [R03] Start X is transfer upper-left X
// [R04] Start X reads live engine position
// [R05] Second start X seeds, reads edge two
// [R06] Destination Y field, twelve bits, per command
// [R07] Same register as fourteen-bit axial step
// [R08] Second Y: edge-two end or step
// [R09] Destination X field, twelve bits, per command
// [R10] Same register as fourteen-bit diagonal step
// [R11] Second X: edge-two end or step
// [R12] Error term seeds line, first edge
// [R13] Software computes error term with offset
// [R14] Second error term for edge two
// [R15] Pixel count sets length or width
// [R16] Count field holds pixels minus one
// [R17] Registers undefined until software writes
// [R18] Reserved bits written zero, read any
// [R19] Access only when enable bit set
// [R20] Parameters sampled at command start
package dlp_pkg;
  localparam logic [15:0] DLP_OFF_START_X = 16'h86e8;
  localparam logic [15:0] DLP_OFF_START_X2 = 16'h86ea;
  localparam logic [15:0] DLP_OFF_DEST_Y = 16'h8ae8;
  localparam logic [15:0] DLP_OFF_Y2 = 16'h8aea;
  localparam logic [15:0] DLP_OFF_DEST_X = 16'h8ee8;
  localparam logic [15:0] DLP_OFF_X2 = 16'h8eea;
  localparam logic [15:0] DLP_OFF_ERR = 16'h92e8;
  localparam logic [15:0] DLP_OFF_ERR2 = 16'h92ea;
  localparam logic [15:0] DLP_OFF_PCNT = 16'h96e8;
  localparam int DLP_NREG = 9;
  localparam logic [15:0] DLP_COORD_MASK = 16'h0fff;
  localparam logic [15:0] DLP_STEP_MASK = 16'h3fff;
  localparam logic [15:0] DLP_RESET_VAL = 16'h0000;
  localparam int DLP_ENABLE_BIT = 0;

  typedef enum {DLP_IDLE, DLP_RUN} dlp_state_t;

  typedef struct packed {
    logic [15:0] start_x;
    logic [15:0] start_x2;
    logic [15:0] dest_y;
    logic [15:0] y2;
    logic [15:0] dest_x;
    logic [15:0] x2;
    logic [15:0] err;
    logic [15:0] err2;
    logic [15:0] pcnt;
  } dlp_params_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dlp_bus_t;
endpackage

//--- test/dlp_regs_monitor.sv
// Checker for the parameter register bank ports
`timescale 1ns/1ps
`default_nettype none
module dlp_regs_monitor
  import dlp_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [7:0] sys_config_i,
  input wire dlp_bus_t bus_i,
  input wire logic [15:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic cmd_start_i,
  input wire logic cmd_done_i,
  input wire dlp_params_t params_o,
  input wire logic busy_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  chk_rd_answer: assert property (ce_i && bus_i.rd |=> rvalid_o) else $error("read lost");
  chk_rv_pulse: assert property (ce_i && !bus_i.rd |=> !rvalid_o) else $error("stray valid");
  chk_off_read: assert property (ce_i && bus_i.rd && !sys_config_i[0] |=> rdata_o == 16'h0000)
    else $error("locked read");
  chk_cnt_resv: assert property (ce_i && bus_i.rd && bus_i.addr == DLP_OFF_PCNT |=> rdata_o[15:12] == 4'h0)
    else $error("count bits");
  chk_start_busy: assert property (ce_i && cmd_start_i && !busy_o |=> busy_o) else $error("no start");
  chk_done_idle: assert property (ce_i && cmd_done_i && busy_o |=> !busy_o) else $error("no done");
  chk_snap_hold: assert property (busy_o ##1 busy_o |-> $stable(params_o)) else $error("snap moved");
  chk_snap_resv: assert property (params_o.start_x[15:12] == 4'h0 && params_o.err[15:14] == 2'h0)
    else $error("snap bits");
endmodule
bind dlp_regs dlp_regs_monitor u_mon (.*);
`default_nettype wire

//--- test/dlp_regs_tb.sv
// Self-checking bench for the parameter register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; $display("unexpected %s %h %h", n, e, g); end end
module dlp_regs_tb;
  import dlp_pkg::*;
  logic clock_i = 0, rstn_i = 0, ce = 1, st = 0, dn = 0, pu = 0, rv, busy, gv;
  logic [7:0] cfg = 8'h01;
  logic [11:0] px = 12'h000, px2 = 12'h000;
  logic [15:0] rdata, got;
  dlp_bus_t bus = '0;
  dlp_params_t prm;
  int failures = 0, n_tests = 0;
  logic [47:0] rows [10] = '{{DLP_OFF_START_X, 16'hf123, 16'h0123}, {DLP_OFF_DEST_Y, 16'hffff, 16'h3fff},
    {DLP_OFF_DEST_X, 16'hfff6, 16'h3ff6}, {DLP_OFF_ERR, 16'hfffd, 16'h3ffd}, {DLP_OFF_PCNT, 16'hf00f, 16'h000f},
    {DLP_OFF_START_X2, 16'h0456, 16'h0456}, {DLP_OFF_Y2, 16'h0789, 16'h0789}, {DLP_OFF_X2, 16'h0abc, 16'h0abc},
    {DLP_OFF_ERR2, 16'h1234, 16'h1234}, {16'h86ec, 16'h5555, 16'h0000}};
  always #12.5 clock_i = ~clock_i;
  dlp_regs u_dut (.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce), .sys_config_i(cfg), .bus_i(bus), .rdata_o(rdata),
    .rvalid_o(rv), .cmd_start_i(st), .cmd_done_i(dn), .pos_upd_i(pu), .pos_x_i(px), .pos_x2_i(px2),
    .params_o(prm), .busy_o(busy));
  task automatic tick(); @(posedge clock_i); #1; endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d); bus.wr = 1; bus.addr = a; bus.wdata = d; tick();
    bus.wr = 0; tick(); endtask
  task automatic rd(input logic [15:0] a); bus.rd = 1; bus.addr = a; tick(); got = rdata; gv = rv; bus.rd = 0;
    tick(); endtask
  task automatic end_sim();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin #100000; failures++; end_sim(); end
  initial begin
    repeat (8) tick();
    rstn_i = 1;
    tick();
    `CHK("busy", 1'b0, busy)
    foreach (rows[i]) begin
      wr(rows[i][47:32], rows[i][31:16]);
      rd(rows[i][47:32]);
      `CHK("reg", rows[i][15:0], got)
      `CHK("rvalid", 1'b1, gv)
    end
    $display("table done");
    cfg = 8'h00;
    wr(DLP_OFF_START_X, 16'h0aaa);
    rd(DLP_OFF_START_X);
    `CHK("locked", 16'h0000, got)
    cfg = 8'h01;
    rd(DLP_OFF_START_X);
    `CHK("kept", 16'h0123, got)
    wr(DLP_OFF_PCNT, 16'h0005);
    st = 1;
    tick();
    st = 0;
    `CHK("snap", 16'h0005, prm.pcnt)
    wr(DLP_OFF_PCNT, 16'h0009);
    `CHK("held", 16'h0005, prm.pcnt)
    px = 12'h7a1;
    px2 = 12'h3b2;
    pu = 1;
    tick();
    pu = 0;
    rd(DLP_OFF_START_X);
    `CHK("pos", 16'h07a1, got)
    rd(DLP_OFF_START_X2);
    `CHK("pos2", 16'h03b2, got)
    dn = 1;
    tick();
    dn = 0;
    `CHK("idle", 1'b0, busy)
    $display("command done");
    ce = 0;
    wr(DLP_OFF_START_X, 16'h0bbb);
    ce = 1;
    rd(DLP_OFF_START_X);
    `CHK("frozen", 16'h07a1, got)
    $display("enable done");
    wr(DLP_OFF_DEST_Y, 16'h0004);
    wr(DLP_OFF_DEST_X, 16'h3ffa);
    wr(DLP_OFF_ERR, 16'h3ffe);
    wr(DLP_OFF_PCNT, 16'h0004);
    st = 1;
    tick();
    st = 0;
    `CHK("err", 16'h3ffe, prm.err)
    `CHK("axial", 16'h0004, prm.dest_y)
    `CHK("diag", 16'h3ffa, prm.dest_x)
    `CHK("count", 16'h0004, prm.pcnt)
    dn = 1;
    tick();
    dn = 0;
    $display("line done");
    st = 1;
    tick();
    st = 0;
    rstn_i = 0;
    tick();
    tick();
    rstn_i = 1;
    tick();
    `CHK("rst busy", 1'b0, busy)
    `CHK("rst snap", 16'h0000, prm.pcnt)
    `CHK("rst rdata", 16'h0000, rdata)
    $display("reset done");
    end_sim();
  end
endmodule
`default_nettype wire
